/* File: verilog/fifo_ctl_pkg.sv */
// Package: constants and carriers for the UART FIFO control block
`default_nettype none
package fifo_ctl_pkg;
    localparam int FIFO_DEPTH = 64;
    localparam int CNT_W = 7;
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_RXCLR_BIT = 1;
    localparam int FCR_TXCLR_BIT = 2;
    localparam int FCR_TXTRIG_LSB = 4;
    localparam int FCR_RXTRIG_LSB = 6;
    localparam logic [7:0] FCR_RESET = 8'h00;
    localparam logic [7:0] LCR_RESET = 8'h1d;
    localparam logic [6:0] RX_TRIG_L0 = 7'h08;
    localparam logic [6:0] RX_TRIG_L1 = 7'h10;
    localparam logic [6:0] RX_TRIG_L2 = 7'h38;
    localparam logic [6:0] RX_TRIG_L3 = 7'h3c;
    localparam logic [6:0] TX_TRIG_L0 = 7'h08;
    localparam logic [6:0] TX_TRIG_L1 = 7'h10;
    localparam logic [6:0] TX_TRIG_L2 = 7'h20;
    localparam logic [6:0] TX_TRIG_L3 = 7'h38;
    // Crystal cycles a clear is held
    localparam int CLEAR_CYCLES = 2;

    typedef struct packed {
        logic [1:0] rx_trigger;
        logic [1:0] tx_trigger;
        logic fifo_enable;
    } fifo_cfg_t;

    // Bit 7 first: divisor latch at the top, word length in bits 1:0
    typedef struct packed {
        logic divisor_latch;
        logic break_ctl;
        logic force_parity;
        logic even_parity;
        logic parity_en;
        logic two_stop;
        logic [1:0] word_length;
    } line_format_t;

    typedef enum logic [1:0] {
        CLR_IDLE = 2'b00,
        CLR_RUN1 = 2'b01,
        CLR_RUN2 = 2'b11
    } clear_state_t;
endpackage : fifo_ctl_pkg
`default_nettype wire

/* File: verilog/byte_fifo.sv */
// Byte FIFO with flip-flop storage, clear input and single-location mode
`default_nettype none
module byte_fifo #(
    parameter int DEPTH = 64,
    parameter int CW = 7
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Control
    input wire logic clear,
    input wire logic single,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    // Level
    output logic [CW-1:0] count
);
    if (DEPTH < 2 || (1 << (CW - 1)) != DEPTH) begin : g_depth_check
        $error("byte_fifo: DEPTH must be 2**(CW-1)");
    end

    logic [7:0] mem_reg [DEPTH];
    logic [CW-2:0] rd_reg, rd_next, wr_reg, wr_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic push, pop;

    always_comb begin
        in_ready = single ? (cnt_reg == '0) : (cnt_reg != CW'(DEPTH));
        out_valid = (cnt_reg != '0);
        // Single mode always uses location zero
        out_data = mem_reg[single ? '0 : rd_reg];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        rd_next = rd_reg;
        wr_next = wr_reg;
        cnt_next = cnt_reg;
        if (clear) begin
            rd_next = '0;
            wr_next = '0;
            cnt_next = '0;
        end else begin
            if (push && !single) wr_next = wr_reg + 1'b1;
            if (pop && !single) rd_next = rd_reg + 1'b1;
            if (push && !pop) cnt_next = cnt_reg + 1'b1;
            else if (pop && !push) cnt_next = cnt_reg - 1'b1;
        end
        count = cnt_reg;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rd_reg <= '0;
            wr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            cnt_reg <= cnt_next;
        end
        if (push && !clear) mem_reg[single ? '0 : wr_reg] <= in_data;
    end
endmodule : byte_fifo
`default_nettype wire

/* File: verilog/uart_fifo_control.sv */
// UART FIFO control: control register, clear sequencing, two FIFOs, thresholds
`default_nettype none
module uart_fifo_control
    import fifo_ctl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock (crystal clock domain) and reset
    input wire logic clock,
    input wire logic reset,
    // Register writes from the host interface
    input wire logic fifo_control_we,
    input wire logic line_format_we,
    input wire logic [7:0] write_data,
    input wire logic enhanced_function_enable,
    // Receive path: shift register to FIFO, FIFO to host
    input wire logic rx_in_valid,
    output logic rx_in_ready,
    input wire logic [7:0] rx_in_data,
    output logic rx_out_valid,
    input wire logic rx_out_ready,
    output logic [7:0] rx_out_data,
    // Transmit path: host to FIFO, FIFO to shift register
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire logic [7:0] tx_in_data,
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output logic [7:0] tx_out_data,
    // Status
    output fifo_ctl_pkg::fifo_cfg_t cfg,
    output fifo_ctl_pkg::line_format_t line_format,
    output logic rx_clear_busy,
    output logic tx_clear_busy,
    output logic rx_threshold,
    output logic tx_threshold
);
    import fifo_ctl_pkg::*;

    if (DEPTH != FIFO_DEPTH) begin : g_depth_check
        $error("uart_fifo_control: DEPTH must be 64");
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and line format registers
    fifo_cfg_t cfg_reg, cfg_next;
    line_format_t lf_reg, lf_next;
    logic rx_clr_req, tx_clr_req;

    always_comb begin
        cfg_next = cfg_reg;
        lf_next = lf_reg;
        rx_clr_req = 1'b0;
        tx_clr_req = 1'b0;
        if (fifo_control_we) begin
            cfg_next.rx_trigger = write_data[FCR_RXTRIG_LSB +: 2];
            if (enhanced_function_enable) begin
                cfg_next.tx_trigger = write_data[FCR_TXTRIG_LSB +: 2];
            end
            cfg_next.fifo_enable = write_data[FCR_EN_BIT];
            rx_clr_req = write_data[FCR_RXCLR_BIT];
            tx_clr_req = write_data[FCR_TXCLR_BIT];
        end
        if (line_format_we) begin
            lf_next = line_format_t'(write_data);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cfg_reg <= fifo_cfg_t'({FCR_RESET[7:4], FCR_RESET[0]});
            lf_reg <= line_format_t'(LCR_RESET);
        end else begin
            cfg_reg <= cfg_next;
            lf_reg <= lf_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clear sequencers, one per FIFO
    clear_state_t rx_st_reg, rx_st_next, tx_st_reg, tx_st_next;

    function automatic clear_state_t clr_step(input clear_state_t s, input logic req);
        case (s)
            CLR_IDLE: clr_step = req ? CLR_RUN1 : CLR_IDLE;
            CLR_RUN1: clr_step = req ? CLR_RUN1 : CLR_RUN2;
            default: clr_step = req ? CLR_RUN1 : CLR_IDLE;
        endcase
    endfunction : clr_step

    always_comb begin
        rx_st_next = clr_step(rx_st_reg, rx_clr_req);
        tx_st_next = clr_step(tx_st_reg, tx_clr_req);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_st_reg <= CLR_IDLE;
            tx_st_reg <= CLR_IDLE;
        end else begin
            rx_st_reg <= rx_st_next;
            tx_st_reg <= tx_st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // FIFOs; clear touches only FIFO state, never the shift registers
    logic [CNT_W-1:0] rx_count, tx_count;
    logic rx_clr, tx_clr;
    logic rx_fv, tx_fv;
    logic [7:0] rx_fd, tx_fd;
    logic rx_ov_reg, tx_ov_reg;
    logic rx_push, tx_push;
    logic [CNT_W-1:0] rx_fill, tx_fill;
    assign rx_clr = (rx_st_reg != CLR_IDLE);
    assign tx_clr = (tx_st_reg != CLR_IDLE);
    // A word is taken only on the handshake the sender sees at the port
    assign rx_push = rx_in_valid && rx_in_ready && !rx_clr;
    assign tx_push = tx_in_valid && tx_in_ready && !tx_clr;

    byte_fifo #(.DEPTH(DEPTH), .CW(CNT_W)) rx_fifo (
        .clock(clock), .reset(reset), .clear(rx_clr),
        .single(!cfg_reg.fifo_enable),
        .in_valid(rx_push), .in_ready(), .in_data(rx_in_data),
        .out_valid(rx_fv), .out_ready(!rx_clr && (!rx_ov_reg || rx_out_ready)),
        .out_data(rx_fd), .count(rx_count)
    );

    byte_fifo #(.DEPTH(DEPTH), .CW(CNT_W)) tx_fifo (
        .clock(clock), .reset(reset), .clear(tx_clr),
        .single(1'b0),
        .in_valid(tx_push), .in_ready(), .in_data(tx_in_data),
        .out_valid(tx_fv), .out_ready(!tx_clr && (!tx_ov_reg || tx_out_ready)),
        .out_data(tx_fd), .count(tx_count)
    );

    // Fill level as the host sees it: FIFO words plus the output stage
    assign rx_fill = rx_count + CNT_W'(rx_ov_reg);
    assign tx_fill = tx_count + CNT_W'(tx_ov_reg);

    ////////////////////////////////////////////////////////////////////////
    // Output stages and thresholds
    logic rx_ov_next, tx_ov_next;
    logic rx_rdy_next, tx_rdy_next;
    logic [7:0] rx_od_reg, rx_od_next, tx_od_reg, tx_od_next;
    logic rx_thr_next, tx_thr_next;
    logic [6:0] rx_lvl, tx_lvl;

    function automatic logic [6:0] rx_level(input logic [1:0] sel);
        case (sel)
            2'h0: rx_level = RX_TRIG_L0;
            2'h1: rx_level = RX_TRIG_L1;
            2'h2: rx_level = RX_TRIG_L2;
            default: rx_level = RX_TRIG_L3;
        endcase
    endfunction : rx_level

    function automatic logic [6:0] tx_level(input logic [1:0] sel);
        case (sel)
            2'h0: tx_level = TX_TRIG_L0;
            2'h1: tx_level = TX_TRIG_L1;
            2'h2: tx_level = TX_TRIG_L2;
            default: tx_level = TX_TRIG_L3;
        endcase
    endfunction : tx_level

    // Ready is registered, so it stays high only if a word still fits after this cycle
    function automatic logic room_left(
        input logic [CNT_W-1:0] fill,
        input logic p,
        input logic one
    );
        room_left = (8'(fill) + 8'(p)) < (one ? 8'h01 : 8'(DEPTH));
    endfunction : room_left

    always_comb begin
        rx_lvl = rx_level(cfg_reg.rx_trigger);
        tx_lvl = tx_level(cfg_reg.tx_trigger);
        rx_ov_next = rx_ov_reg;
        rx_od_next = rx_od_reg;
        tx_ov_next = tx_ov_reg;
        tx_od_next = tx_od_reg;
        if (rx_clr) begin
            rx_ov_next = 1'b0;
        end else if (!rx_ov_reg || rx_out_ready) begin
            rx_ov_next = rx_fv;
            rx_od_next = rx_fd;
        end
        if (tx_clr) begin
            tx_ov_next = 1'b0;
        end else if (!tx_ov_reg || tx_out_ready) begin
            tx_ov_next = tx_fv;
            tx_od_next = tx_fd;
        end
        rx_thr_next = cfg_reg.fifo_enable && (rx_fill >= rx_lvl);
        tx_thr_next = cfg_reg.fifo_enable
            && ((7'(DEPTH) - tx_fill) >= tx_lvl);
        rx_rdy_next = !rx_clr && !rx_clr_req
            && room_left(rx_fill, rx_push, !cfg_reg.fifo_enable);
        tx_rdy_next = !tx_clr && !tx_clr_req
            && room_left(tx_fill, tx_push, 1'b0);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_ov_reg <= 1'b0;
            rx_od_reg <= 8'h00;
            tx_ov_reg <= 1'b0;
            tx_od_reg <= 8'h00;
            rx_threshold <= 1'b0;
            tx_threshold <= 1'b0;
            rx_in_ready <= 1'b0;
            tx_in_ready <= 1'b0;
        end else begin
            rx_ov_reg <= rx_ov_next;
            rx_od_reg <= rx_od_next;
            tx_ov_reg <= tx_ov_next;
            tx_od_reg <= tx_od_next;
            rx_threshold <= rx_thr_next;
            tx_threshold <= tx_thr_next;
            rx_in_ready <= rx_rdy_next;
            tx_in_ready <= tx_rdy_next;
        end
    end

    assign rx_out_valid = rx_ov_reg;
    assign rx_out_data = rx_od_reg;
    assign tx_out_valid = tx_ov_reg;
    assign tx_out_data = tx_od_reg;
    assign cfg = cfg_reg;
    assign line_format = lf_reg;
    // Low state bit is set exactly in the two busy states
    assign rx_clear_busy = rx_st_reg[0];
    assign tx_clear_busy = tx_st_reg[0];
endmodule : uart_fifo_control
`default_nettype wire

/* File: verif/fifo_ctl_checker.sv */
// Checker: timing relations at the FIFO control ports
`default_nettype none
module fifo_ctl_checker
    import fifo_ctl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register writes
    input wire logic fifo_control_we,
    input wire logic line_format_we,
    input wire logic [7:0] write_data,
    input wire logic enhanced_function_enable,
    // Status
    input wire fifo_cfg_t cfg,
    input wire line_format_t line_format,
    input wire logic rx_clear_busy,
    input wire logic tx_clear_busy,
    input wire logic rx_threshold
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    property p_enable;
        fifo_control_we |=> cfg.fifo_enable == $past(write_data[0]);
    endproperty
    a_enable: assert property (p_enable) else $error("fifo enable not applied");
    property p_rx_level;
        fifo_control_we |=> cfg.rx_trigger == $past(write_data[7:6]);
    endproperty
    a_rx_level: assert property (p_rx_level) else $error("rx level not applied");
    property p_tx_level;
        fifo_control_we && enhanced_function_enable |=> cfg.tx_trigger == $past(write_data[5:4]);
    endproperty
    a_tx_level: assert property (p_tx_level) else $error("tx level not applied");
    property p_tx_kept;
        fifo_control_we && !enhanced_function_enable |=> $stable(cfg.tx_trigger);
    endproperty
    a_tx_kept: assert property (p_tx_kept) else $error("tx level changed");
    property p_rx_clear;
        fifo_control_we && write_data[1] |=> rx_clear_busy [*2];
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("rx clear too short");
    property p_rx_done;
        (fifo_control_we && write_data[1]) ##1 !fifo_control_we [*2] |=> !rx_clear_busy;
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("rx clear stuck");
    property p_tx_clear;
        fifo_control_we && write_data[2] |=> tx_clear_busy [*2];
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("tx clear too short");
    property p_rx_only;
        fifo_control_we && !write_data[2] && !tx_clear_busy |=> !tx_clear_busy;
    endproperty
    a_rx_only: assert property (p_rx_only) else $error("tx clear without cause");
    property p_format;
        line_format_we |=> line_format == $past(write_data);
    endproperty
    a_format: assert property (p_format) else $error("line format not applied");
    c_rx_clear: cover property (fifo_control_we && write_data[1]);
    c_tx_clear: cover property (tx_clear_busy);
    c_rx_level: cover property (rx_threshold);
endmodule : fifo_ctl_checker
`default_nettype wire

/* File: verif/host_model.sv */
// Host model: drains the receive stream, promptly or slowly
`default_nettype none
module host_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Stall controls
    input wire logic hold,
    input wire logic slow,
    // Receive stream
    input wire logic rx_out_valid,
    input wire logic [7:0] rx_out_data,
    output logic rx_out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    initial rx_out_ready = 1'h0;
    // Ready every cycle, or every other cycle when slow
    always @(posedge clock) begin
        if (!reset && rx_out_valid && rx_out_ready) got.push_back(rx_out_data);
        rx_out_ready <= !reset && !hold && !(slow && rx_out_ready);
    end
endmodule : host_model
`default_nettype wire

/* File: verif/uart_fifo_control_bench.sv */
// Bench: scenarios for the UART FIFO control block
`default_nettype none
module uart_fifo_control_bench;
    import fifo_ctl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0, reset = 1'h1, fifo_control_we = 1'h0, line_format_we = 1'h0;
    logic enhanced_function_enable = 1'h1, hold = 1'h1, slow = 1'h0, tx_out_ready = 1'h0;
    logic rx_in_valid = 1'h0, tx_in_valid = 1'h0;
    logic [7:0] write_data = 8'h00, rx_in_data = 8'h00, tx_in_data = 8'h00;
    logic rx_in_ready, rx_out_valid, rx_out_ready, tx_in_ready, tx_out_valid;
    logic rx_clear_busy, tx_clear_busy, rx_threshold, tx_threshold;
    logic [7:0] rx_out_data, tx_out_data;
    fifo_cfg_t cfg;
    line_format_t line_format;
    int fail_count = 0, checks = 0, cycles = 0, k;
    always #20 clock = ~clock;
    uart_fifo_control i_dut (.*);
    host_model i_host (.*);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic lf, input logic [7:0] d);
        @(posedge clock);
        {line_format_we, fifo_control_we, write_data} <= {lf, !lf, d};
        @(posedge clock);
        {line_format_we, fifo_control_we} <= 2'h0;
        @(posedge clock);
    endtask : wr
    task automatic push(input logic tx, input int n, input logic [7:0] b, output int m);
        int w;
        logic ok;
        m = 0;
        @(posedge clock);
        while (m < n) begin
            if (tx) {tx_in_valid, tx_in_data} <= {1'h1, 8'(b + m)};
            else {rx_in_valid, rx_in_data} <= {1'h1, 8'(b + m)};
            w = 0;
            do begin
                @(negedge clock);
                w++;
                ok = (tx ? tx_in_ready : rx_in_ready) === 1'h1;
            end while (!ok && w < 20);
            @(posedge clock);
            if (!ok) break;
            m++;
        end
        {tx_in_valid, rx_in_valid} <= 2'h0;
    endtask : push
    task automatic t_reset;
        @(negedge clock);
        chk("cfg", 8'(cfg), 8'h00);
        chk("format", line_format, LCR_RESET);
        wr(1'h1, 8'ha5);
        chk("format", line_format, 8'ha5);
    endtask : t_reset
    task automatic t_trig;
        for (int i = 0; i < 4; i++) begin
            wr(1'h0, 8'(i * 8'h50) | 8'h01);
            chk("rx_level", 8'(cfg.rx_trigger), 8'(i));
            chk("tx_level", 8'(cfg.tx_trigger), 8'(i));
        end
        enhanced_function_enable <= 1'h0;
        wr(1'h0, 8'h01);
        enhanced_function_enable <= 1'h1;
        chk("tx_kept", 8'(cfg.tx_trigger), 8'h03);
    endtask : t_trig
    task automatic t_thr;
        push(1'h0, 7, 8'h00, k);
        repeat (3) @(negedge clock);
        chk("rx_thr7", 8'(rx_threshold), 8'h00);
        push(1'h0, 1, 8'h07, k);
        repeat (3) @(negedge clock);
        chk("rx_thr8", 8'(rx_threshold), 8'h01);
        push(1'h1, 8, 8'h40, k);
        repeat (3) @(negedge clock);
        chk("tx_thr56", 8'(tx_threshold), 8'h01);
        push(1'h1, 1, 8'h48, k);
        repeat (3) @(negedge clock);
        chk("tx_thr55", 8'(tx_threshold), 8'h00);
    endtask : t_thr
    task automatic t_clear(input logic tx);
        wr(1'h0, tx ? 8'h35 : 8'h33);
        @(negedge clock);
        chk("busy", 8'({tx_clear_busy, rx_clear_busy}), tx ? 8'h02 : 8'h01);
        @(negedge clock);
        chk("idle", 8'({tx_clear_busy, rx_clear_busy}), 8'h00);
        // Host keeps off the data for two clocks after a clear
        repeat (2) @(negedge clock);
        chk("valid", 8'({tx_out_valid, rx_out_valid}), tx ? 8'h00 : 8'h02);
    endtask : t_clear
    task automatic t_fill;
        push(1'h0, 70, 8'h00, k);
        chk("fill", 8'(k), 8'h40);
        @(posedge clock);
        {hold, slow} <= 2'h1;
        for (int w = 0; w < 400 && i_host.got.size() < 64; w++) @(posedge clock);
        repeat (2) @(negedge clock);
        chk("drained", 8'(i_host.got.size()), 8'h40);
        chk("empty", 8'(rx_out_valid), 8'h00);
        for (int i = 0; i < 64; i++) chk("order", i_host.got[i], 8'(i));
    endtask : t_fill
    task automatic t_single;
        @(posedge clock);
        hold <= 1'h1;
        wr(1'h0, 8'h00);
        push(1'h0, 2, 8'h80, k);
        chk("single", 8'(k), 8'h01);
        chk("thr_off", 8'(rx_threshold), 8'h00);
    endtask : t_single
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'h0;
        t_reset();
        t_trig();
        t_thr();
        chk("tx_kept", 8'(tx_out_valid), 8'h01);
        chk("tx_data", tx_out_data, 8'h40);
        @(posedge clock);
        tx_out_ready <= 1'h1;
        @(posedge clock);
        tx_out_ready <= 1'h0;
        @(negedge clock);
        chk("tx_next", tx_out_data, 8'h41);
        t_clear(1'h0);
        t_clear(1'h1);
        t_fill();
        t_single();
        print_verdict();
    end
endmodule : uart_fifo_control_bench
bind uart_fifo_control fifo_ctl_checker i_chk (
    .clock(clock), .reset(reset), .fifo_control_we(fifo_control_we),
    .line_format_we(line_format_we), .write_data(write_data),
    .enhanced_function_enable(enhanced_function_enable), .cfg(cfg),
    .line_format(line_format), .rx_clear_busy(rx_clear_busy),
    .tx_clear_busy(tx_clear_busy), .rx_threshold(rx_threshold)
);
`default_nettype wire
